// File: core/cfi_field_dec.sv
/*
  Decodes a collected injection header into forwarding and rewrite
  side-band. Assumes an all-zero header for frames without one.
*/
`timescale 1ns/1ps
`default_nettype none

module cfi_field_dec (
  // Header
  input wire logic [cfi_pkg::HDR_BITS-1:0] hdr,
  // Forwarding
  output logic bypass,
  output logic masquerade_enable,
  output logic [3:0] ingress,
  output logic [cfi_pkg::DESTINATION_SET_W-1:0] destination_set,
  output logic [cfi_pkg::CPUQ_W-1:0] cpuq,
  output logic [cfi_pkg::QOS_W-1:0] qos,
  output logic [cfi_pkg::INJECTING_PORT_NUMBER_W-1:0] injecting_port_number,
  // Rewrite
  output cfi_pkg::cfi_rew_cmd_type cmd,
  output logic [cfi_pkg::ARG_W-1:0] arg,
  output logic egr_delay,
  output logic smac_rep,
  output logic ts_cpu,
  output logic [cfi_pkg::REWRITER_TIME_VALUE_W-1:0] rewriter_time_value
);

  logic [cfi_pkg::REWRITER_OPERATION_W-1:0] op;

  always_comb begin
    op = hdr[cfi_pkg::REWRITER_OPERATION_LSB +: cfi_pkg::REWRITER_OPERATION_W];
    bypass = hdr[cfi_pkg::BYPASS_BIT]; // R6 R7
    // Masquerade and source MAC replace only exist without bypass
    masquerade_enable = !bypass && hdr[cfi_pkg::MASQUERADE_ENABLE_BIT]; // R8 R10
    smac_rep = !bypass && hdr[cfi_pkg::SMAC_REPL_BIT]; // R11
    ingress = masquerade_enable ? hdr[cfi_pkg::MASQUERADE_INGRESS_PORT_LSB +: cfi_pkg::MASQUERADE_INGRESS_PORT_W]
                   : cfi_pkg::CPU_PORT_MAIN; // R2 R9
    destination_set = bypass ? hdr[cfi_pkg::DESTINATION_SET_LSB +: cfi_pkg::DESTINATION_SET_W]
                  : '0; // R21
    cpuq = bypass ? hdr[cfi_pkg::CPUQ_LSB +: cfi_pkg::CPUQ_W] : '0; // R6
    qos = bypass ? hdr[cfi_pkg::QOS_LSB +: cfi_pkg::QOS_W] : '0; // R6
    injecting_port_number = hdr[cfi_pkg::INJECTING_PORT_NUMBER_LSB +: cfi_pkg::INJECTING_PORT_NUMBER_W]; // R22
    rewriter_time_value = hdr[cfi_pkg::REWRITER_TIME_VALUE_LSB +: cfi_pkg::REWRITER_TIME_VALUE_W]; // R23
    cmd = cfi_pkg::CMD_NONE;
    if (bypass) begin // R12
      if (op[3:0] == cfi_pkg::OP4_NONE) begin
        cmd = cfi_pkg::CMD_NONE; // R13
      end else if (op[3:0] == cfi_pkg::OP4_SWAP) begin
        cmd = cfi_pkg::CMD_SWAP; // R14
      end else begin
        case (op[2:0])
          cfi_pkg::OP3_DSCP: cmd = cfi_pkg::CMD_DSCP; // R15
          cfi_pkg::OP3_ONESTEP: cmd = cfi_pkg::CMD_ONESTEP; // R16
          cfi_pkg::OP3_TWOSTEP: cmd = cfi_pkg::CMD_TWOSTEP; // R17
          cfi_pkg::OP3_ORIGIN: cmd = cfi_pkg::CMD_ORIGIN; // R19
          default: cmd = cfi_pkg::CMD_NONE;
        endcase
      end
    end
    arg = ((cmd == cfi_pkg::CMD_DSCP) || (cmd == cfi_pkg::CMD_TWOSTEP))
          ? op[cfi_pkg::ARG_LSB +: cfi_pkg::ARG_W] : '0; // R15 R17
    egr_delay = (cmd == cfi_pkg::CMD_ONESTEP) &&
                op[cfi_pkg::EGR_DELAY_BIT]; // R16
    ts_cpu = (cmd == cfi_pkg::CMD_TWOSTEP) &&
             (arg <= cfi_pkg::TS_ID_CPU_MAX); // R18
  end

endmodule

`default_nettype wire

// File: core/cfi_hdr_parse.sv
/*
  Per-group header collector: swallows the leading header bytes of
  each frame when expected and holds them until the frame ends.
  Assumes take is high only on accepted bytes of this group.
*/
`timescale 1ns/1ps
`default_nettype none

module cfi_hdr_parse (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Configuration
  input wire logic expect_hdr,
  // Accepted byte
  input wire logic take,
  input wire logic [7:0] data,
  input wire logic eof,
  // Parse result
  output logic hdr_byte,
  output logic present,
  output logic [cfi_pkg::HDR_BITS-1:0] hdr
);

  typedef struct packed {
    cfi_pkg::cfi_prs_state_type st;
    logic [cfi_pkg::CNT_W-1:0] cnt;
    logic present;
    logic [cfi_pkg::HDR_BITS-1:0] hdr;
  } cfi_prs_type;

  cfi_prs_type s_r;
  cfi_prs_type s_nxt;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    if (take) begin
      case (s_r.st)
        cfi_pkg::PRS_IDLE: begin
          s_nxt.present = 1'b0;
          if (expect_hdr) begin // R5
            s_nxt.hdr = {s_r.hdr[cfi_pkg::HDR_BITS-9:0], data}; // R4
            s_nxt.cnt = {{(cfi_pkg::CNT_W-1){1'b0}}, 1'b1};
            s_nxt.st = eof ? cfi_pkg::PRS_IDLE : cfi_pkg::PRS_HDR;
          end else begin
            // Leading bytes are frame data
            s_nxt.st = eof ? cfi_pkg::PRS_IDLE : cfi_pkg::PRS_BODY; // R24
          end
        end
        cfi_pkg::PRS_HDR: begin
          s_nxt.hdr = {s_r.hdr[cfi_pkg::HDR_BITS-9:0], data}; // R4
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (eof) begin
            // Runt: frame ended inside its header, dropped
            s_nxt.st = cfi_pkg::PRS_IDLE;
          end else if (s_r.cnt == cfi_pkg::HDR_LAST) begin
            s_nxt.st = cfi_pkg::PRS_BODY; // R4
            s_nxt.present = 1'b1;
          end
        end
        cfi_pkg::PRS_BODY: begin
          if (eof) begin
            s_nxt.st = cfi_pkg::PRS_IDLE;
            s_nxt.present = 1'b0;
          end
        end
        default: begin
          s_nxt.st = cfi_pkg::PRS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hdr_byte = (s_r.st == cfi_pkg::PRS_HDR) ||
                    ((s_r.st == cfi_pkg::PRS_IDLE) && expect_hdr);
  assign present = s_r.present;
  assign hdr = s_r.hdr;

  // ==========================================================
  // Checks
  chk_hdr_length: assert property (@(posedge core_clk) // R4
    disable iff (!reset_n)
    (s_r.st == cfi_pkg::PRS_BODY) && ($past(s_r.st) == cfi_pkg::PRS_HDR)
    |-> $past(s_r.cnt) == cfi_pkg::HDR_LAST && s_r.present)
    else $error("header ended at wrong byte count");

endmodule

`default_nettype wire

// File: core/cfi_inject.sv
/*
  CPU frame injection front end: two injection groups, per-frame
  header parsing and decode, one byte stream into the switch core
  with the frame's side-band held from start to end of frame.
  Assumes the switch core takes one byte every cycle without stall
  and that configuration ports are driven from core_clk logic.
*/
// Notes on behaviour
// R1: Two independent injection groups feed CPU ports 11 and 12 separately.
// R2: Every unmasqueraded injected frame enters the core as arriving on port 11.
// R3: Source preference lets the CPU port win egress queue arbitration.
// R4: First 20 bytes of each frame are the header; frame follows.
// R5: Header parsed only where the port's header-expect setting is on.
// R6: Bypass bit 127 takes destination, CPU queue, QoS, tags from header.
// R7: Without bypass the analyzer classifies and forwards the frame normally.
// R8: Masquerade bit 126 makes the frame appear from the masquerade port.
// R9: Masquerade port is the 4-bit field at 122, used only when enabled.
// R10: CPU sets masquerade fields only without bypass; rewriter bits overlap.
// R11: Without bypass, bit 126 replaces source MAC with egress-port address.
// R12: With bypass, 9-bit field at 117 is the egress rewrite command.
// R13: Low four command bits zero means no rewrite.
// R14: Low four bits 8 swaps MAC addresses, clearing bit 40 of new SMAC.
// R15: Low three bits 1 remarks DSCP using command bits 8 to 3.
// R16: Low three bits 2 adds residence time; bit 5 adds egress delay.
// R17: Low three bits 3 stores departure timestamp tagged with bits 8 to 3.
// R18: Timestamp identifiers 0 to 3 belong to CPU injected frames.
// R19: Low three bits 5 writes departure time of day into origin field.
// R20: CPU writes zero to command bits the chosen command leaves undefined.
// R21: 12-bit destination set at bit 56 used with bypass; top bit CPU.
// R22: 4-bit field at 43 carries the injecting port number, 0 to 12.
// R23: 32-bit value at 85 may hold injection start time for residence.
// R24: Without header-expect, leading bytes are data, default forwarding.
`timescale 1ns/1ps
`default_nettype none

module cfi_inject (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Configuration
  input wire logic [1:0] expect_injection_header,
  input wire logic cpu_source_preference,
  // Injection group 0 (port 11)
  input wire logic grp0_valid,
  input wire logic [7:0] grp0_data,
  input wire logic grp0_eof,
  output logic grp0_ready,
  // Injection group 1 (port 12)
  input wire logic grp1_valid,
  input wire logic [7:0] grp1_data,
  input wire logic grp1_eof,
  output logic grp1_ready,
  // Frame stream into the switch core
  output logic core_valid,
  output logic [7:0] core_data,
  output logic core_sof,
  output logic core_eof,
  // Frame side-band, held for the whole frame
  output logic [3:0] core_group_port,
  output logic [3:0] core_ingress_port,
  output logic core_masquerade,
  output logic core_hdr_seen,
  output logic core_bypass,
  output logic [cfi_pkg::DESTINATION_SET_W-1:0] core_destination_set,
  output logic [cfi_pkg::CPUQ_W-1:0] core_cpu_queue,
  output logic [cfi_pkg::QOS_W-1:0] core_field_a,
  output logic [cfi_pkg::INJECTING_PORT_NUMBER_W-1:0] core_injecting_port_number,
  output logic core_prefer_src,
  // Rewrite side-band
  output cfi_pkg::cfi_rew_cmd_type core_rew_cmd,
  output logic [cfi_pkg::ARG_W-1:0] core_rew_arg,
  output logic core_egress_delay,
  output logic core_smac_replace,
  output logic core_mac_swap,
  output logic core_ts_id_cpu,
  output logic [cfi_pkg::REWRITER_TIME_VALUE_W-1:0] core_rewriter_time_value
);

  typedef struct packed {
    logic gnt_v;
    logic gnt_i;
    logic rr;
    logic [1:0] rdy;
    logic mid;
    logic valid;
    logic [7:0] data;
    logic sof;
    logic eof;
    logic [3:0] grp_port;
    logic [3:0] ingress;
    logic masquerade_enable;
    logic hdr_seen;
    logic bypass;
    logic [cfi_pkg::DESTINATION_SET_W-1:0] destination_set;
    logic [cfi_pkg::CPUQ_W-1:0] cpuq;
    logic [cfi_pkg::QOS_W-1:0] qos;
    logic [cfi_pkg::INJECTING_PORT_NUMBER_W-1:0] injecting_port_number;
    logic prefer;
    cfi_pkg::cfi_rew_cmd_type cmd;
    logic [cfi_pkg::ARG_W-1:0] arg;
    logic egr_delay;
    logic smac_rep;
    logic swap;
    logic ts_cpu;
    logic [cfi_pkg::REWRITER_TIME_VALUE_W-1:0] rewriter_time_value;
  } cfi_top_type;

  cfi_top_type s_r;
  cfi_top_type s_nxt;

  // ==========================================================
  // Per-group header collection
  logic [1:0] g_valid;
  logic [1:0] g_eof;
  logic [1:0] take;
  logic [1:0] hdr_byte;
  logic [1:0] present;
  logic [7:0] g_data [2];
  logic [cfi_pkg::HDR_BITS-1:0] g_hdr [2];
  logic [cfi_pkg::HDR_BITS-1:0] hdr_sel;

  assign g_valid = {grp1_valid, grp0_valid};
  assign g_eof = {grp1_eof, grp0_eof};
  assign g_data[0] = grp0_data;
  assign g_data[1] = grp1_data;
  assign take = g_valid & s_r.rdy;

  // Each group keeps its own header parser; one decoder serves the granted group
  for (genvar g = 0; g < 2; g++) begin : g_grp // R1
    cfi_hdr_parse u_parse (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .expect_hdr(expect_injection_header[g]), // R5
      .take(take[g]),
      .data(g_data[g]),
      .eof(g_eof[g]),
      .hdr_byte(hdr_byte[g]),
      .present(present[g]),
      .hdr(g_hdr[g])
    );
  end

  // ==========================================================
  // Decode of the granted group's header
  logic d_bypass;
  logic d_masquerade_enable;
  logic [3:0] d_ingress;
  logic [cfi_pkg::DESTINATION_SET_W-1:0] d_destination_set;
  logic [cfi_pkg::CPUQ_W-1:0] d_cpuq;
  logic [cfi_pkg::QOS_W-1:0] d_qos;
  logic [cfi_pkg::INJECTING_PORT_NUMBER_W-1:0] d_injecting_port_number;
  cfi_pkg::cfi_rew_cmd_type d_cmd;
  logic [cfi_pkg::ARG_W-1:0] d_arg;
  logic d_egr_delay;
  logic d_smac_rep;
  logic d_ts_cpu;
  logic [cfi_pkg::REWRITER_TIME_VALUE_W-1:0] d_rewriter_time_value;

  // No header present decodes as all zero: default forwarding
  assign hdr_sel = present[s_r.gnt_i] ? g_hdr[s_r.gnt_i] : '0; // R24

  cfi_field_dec u_dec (
    .hdr(hdr_sel),
    .bypass(d_bypass),
    .masquerade_enable(d_masquerade_enable),
    .ingress(d_ingress),
    .destination_set(d_destination_set),
    .cpuq(d_cpuq),
    .qos(d_qos),
    .injecting_port_number(d_injecting_port_number),
    .cmd(d_cmd),
    .arg(d_arg),
    .egr_delay(d_egr_delay),
    .smac_rep(d_smac_rep),
    .ts_cpu(d_ts_cpu),
    .rewriter_time_value(d_rewriter_time_value)
  );

  // ==========================================================
  // Grant, stream and side-band
  logic cur_take;
  logic cur_body;

  assign cur_take = s_r.gnt_v && take[s_r.gnt_i];
  assign cur_body = cur_take && !hdr_byte[s_r.gnt_i];

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.sof = 1'b0;
    s_nxt.eof = 1'b0;
    if (s_r.gnt_v) begin
      if (cur_body) begin // R4
        s_nxt.valid = 1'b1;
        s_nxt.data = g_data[s_r.gnt_i];
        s_nxt.eof = g_eof[s_r.gnt_i];
        s_nxt.sof = !s_r.mid;
        s_nxt.mid = !g_eof[s_r.gnt_i];
        if (!s_r.mid) begin
          s_nxt.grp_port = s_r.gnt_i ? cfi_pkg::CPU_PORT_ALT
                                     : cfi_pkg::CPU_PORT_MAIN; // R1
          s_nxt.ingress = d_ingress; // R2 R8
          s_nxt.masquerade_enable = d_masquerade_enable; // R8
          s_nxt.hdr_seen = present[s_r.gnt_i];
          s_nxt.bypass = d_bypass; // R6 R7
          s_nxt.destination_set = d_destination_set; // R21
          s_nxt.cpuq = d_cpuq;
          s_nxt.qos = d_qos;
          s_nxt.injecting_port_number = d_injecting_port_number; // R22
          s_nxt.prefer = cpu_source_preference; // R3
          s_nxt.cmd = d_cmd; // R12
          s_nxt.arg = d_arg;
          s_nxt.egr_delay = d_egr_delay; // R16
          s_nxt.smac_rep = d_smac_rep; // R11
          s_nxt.swap = d_cmd == cfi_pkg::CMD_SWAP; // R14
          s_nxt.ts_cpu = d_ts_cpu; // R18
          s_nxt.rewriter_time_value = d_rewriter_time_value; // R23
        end
      end
      // Frame end releases the group for the other one
      if (cur_take && g_eof[s_r.gnt_i]) begin
        s_nxt.gnt_v = 1'b0;
      end
    end else if (g_valid[s_r.rr]) begin
      s_nxt.gnt_v = 1'b1;
      s_nxt.gnt_i = s_r.rr;
      s_nxt.rr = !s_r.rr;
    end else if (g_valid[!s_r.rr]) begin
      s_nxt.gnt_v = 1'b1;
      s_nxt.gnt_i = !s_r.rr;
    end
    s_nxt.rdy = s_nxt.gnt_v ? (2'b01 << s_nxt.gnt_i) : 2'b00;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign grp0_ready = s_r.rdy[0];
  assign grp1_ready = s_r.rdy[1];
  assign core_valid = s_r.valid;
  assign core_data = s_r.data;
  assign core_sof = s_r.sof;
  assign core_eof = s_r.eof;
  assign core_group_port = s_r.grp_port;
  assign core_ingress_port = s_r.ingress;
  assign core_masquerade = s_r.masquerade_enable;
  assign core_hdr_seen = s_r.hdr_seen;
  assign core_bypass = s_r.bypass;
  assign core_destination_set = s_r.destination_set;
  assign core_cpu_queue = s_r.cpuq;
  assign core_field_a = s_r.qos;
  assign core_injecting_port_number = s_r.injecting_port_number;
  assign core_prefer_src = s_r.prefer;
  assign core_rew_cmd = s_r.cmd;
  assign core_rew_arg = s_r.arg;
  assign core_egress_delay = s_r.egr_delay;
  assign core_smac_replace = s_r.smac_rep;
  assign core_mac_swap = s_r.swap;
  assign core_ts_id_cpu = s_r.ts_cpu;
  assign core_rewriter_time_value = s_r.rewriter_time_value;

  // ==========================================================
  // Checks
  logic [cfi_pkg::CNT_W:0] skip_cnt_r;
  logic [cfi_pkg::CNT_W:0] skip_at_sof_r;

  // Header bytes swallowed ahead of each frame's first byte
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      skip_cnt_r <= '0;
      skip_at_sof_r <= '0;
    end else if (cur_body && !s_r.mid) begin
      skip_at_sof_r <= skip_cnt_r;
      skip_cnt_r <= '0;
    end else if (cur_take && g_eof[s_r.gnt_i]) begin
      skip_cnt_r <= '0;
    end else if (cur_take) begin
      skip_cnt_r <= skip_cnt_r + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_first_body;
    cur_body && !s_r.mid;
  endsequence

  sequence seq_last_take;
    cur_take && g_eof[s_r.gnt_i];
  endsequence

  chk_group_port: assert property (seq_first_body |=> // R1
    core_valid && core_sof &&
    core_group_port == ($past(s_r.gnt_i) ? cfi_pkg::CPU_PORT_ALT
                                         : cfi_pkg::CPU_PORT_MAIN))
    else $error("frame start missing or wrong group port");
  chk_ingress_main: assert property ( // R2
    core_valid && !core_masquerade
    |-> core_ingress_port == cfi_pkg::CPU_PORT_MAIN)
    else $error("unmasqueraded frame not on port 11");
  chk_prefer_src: assert property ( // R3
    core_valid && core_sof |-> core_prefer_src == $past(cpu_source_preference))
    else $error("source preference not taken with frame");
  chk_hdr_skip: assert property ( // R4
    core_valid && core_sof && core_hdr_seen
    |-> skip_at_sof_r == (cfi_pkg::CNT_W + 1)'(cfi_pkg::HDR_BYTES))
    else $error("header length not twenty bytes");
  chk_no_hdr_dflt: assert property ( // R24
    core_valid && core_sof && !core_hdr_seen
    |-> skip_at_sof_r == '0 && !core_bypass && !core_masquerade &&
        core_rew_cmd == cfi_pkg::CMD_NONE)
    else $error("headerless frame not default forwarded");
  chk_bypass_excl: assert property ( // R6
    core_valid && core_bypass |-> !core_masquerade && !core_smac_replace)
    else $error("masquerade or SMAC replace with bypass");
  chk_no_rewrite: assert property ( // R12
    core_valid && !core_bypass
    |-> core_rew_cmd == cfi_pkg::CMD_NONE && core_destination_set == '0)
    else $error("rewrite command without bypass");
  chk_swap_cmd: assert property ( // R14
    core_valid |-> core_mac_swap == (core_rew_cmd == cfi_pkg::CMD_SWAP))
    else $error("MAC swap flag disagrees with command");
  chk_egress_delay: assert property ( // R16
    core_valid && core_egress_delay
    |-> core_rew_cmd == cfi_pkg::CMD_ONESTEP && core_rew_arg == '0)
    else $error("egress delay outside one-step");
  chk_group_release: assert property ( // R1
    seq_last_take |=> !grp0_ready && !grp1_ready ##1 !core_valid)
    else $error("group not released after frame end");

endmodule

`default_nettype wire

// File: core/cfi_pkg.sv
/*
  Constants and types for the CPU frame injection header block.
  Assumes one switch-core clock; header bits are counted with the
  first written byte landing in bits 159:152.
*/
package cfi_pkg;

  // ==========================================================
  // Header geometry
  localparam int HDR_BYTES = 20;
  localparam int HDR_BITS = HDR_BYTES * 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] HDR_LAST = CNT_W'(HDR_BYTES - 1);

  // ==========================================================
  // Port numbers of the two CPU ports
  localparam logic [3:0] CPU_PORT_MAIN = 4'hb;
  localparam logic [3:0] CPU_PORT_ALT = 4'hc;

  // ==========================================================
  // Field positions
  localparam int BYPASS_BIT = 127;
  localparam int MASQUERADE_ENABLE_BIT = 126;
  localparam int MASQUERADE_INGRESS_PORT_LSB = 122;
  localparam int MASQUERADE_INGRESS_PORT_W = 4;
  localparam int SMAC_REPL_BIT = 126;
  localparam int REWRITER_OPERATION_LSB = 117;
  localparam int REWRITER_OPERATION_W = 9;
  localparam int REWRITER_TIME_VALUE_LSB = 85;
  localparam int REWRITER_TIME_VALUE_W = 32;
  localparam int DESTINATION_SET_LSB = 56;
  localparam int DESTINATION_SET_W = 12;
  localparam int INJECTING_PORT_NUMBER_LSB = 43;
  localparam int INJECTING_PORT_NUMBER_W = 4;
  localparam int CPUQ_LSB = 20;
  localparam int CPUQ_W = 8;
  localparam int QOS_LSB = 17;
  localparam int QOS_W = 3;

  // ==========================================================
  // Rewriter operation encodings
  localparam logic [3:0] OP4_NONE = 4'h0;
  localparam logic [3:0] OP4_SWAP = 4'h8;
  localparam logic [2:0] OP3_DSCP = 3'h1;
  localparam logic [2:0] OP3_ONESTEP = 3'h2;
  localparam logic [2:0] OP3_TWOSTEP = 3'h3;
  localparam logic [2:0] OP3_ORIGIN = 3'h5;
  localparam int EGR_DELAY_BIT = 5;
  localparam int ARG_LSB = 3;
  localparam int ARG_W = 6;
  localparam logic [ARG_W-1:0] TS_ID_CPU_MAX = 6'h03;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SWAP = 3'h1,
    CMD_DSCP = 3'h2,
    CMD_ONESTEP = 3'h3,
    CMD_TWOSTEP = 3'h4,
    CMD_ORIGIN = 3'h5
  } cfi_rew_cmd_type;

  typedef enum logic [1:0] {
    PRS_IDLE = 2'b00,
    PRS_HDR = 2'b01,
    PRS_BODY = 2'b11
  } cfi_prs_state_type;

endpackage

// File: test/cfi_cpu_model.sv
/*
  CPU side of one injection group: offers a queue of bytes and holds
  each one until the group takes it.
  Assumes send is called just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module cfi_cpu_model (
  // Clock
  input wire logic core_clk,
  // Group side
  output logic valid,
  output logic [7:0] data,
  output logic eof,
  input wire logic ready
);
  initial begin
    valid = 1'b0;
    data = 8'h00;
    eof = 1'b0;
  end

  // Header bytes lead the queue when the caller puts them there
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      #1;
      valid = 1'b1;
      data = b[i];
      eof = (i == b.size() - 1);
      while (ready !== 1'b1) begin
        @(posedge core_clk);
        #1;
      end
      @(posedge core_clk);
    end
    #1;
    valid = 1'b0;
    eof = 1'b0;
    // Released bus shows no stale byte
    data = ~data;
  endtask
endmodule

`default_nettype wire

// File: test/cfi_inject_tb.sv
/*
  Self-checking bench for the injection front end.
  Assumes the core side never stalls the byte stream.
*/
`timescale 1ns/1ps
`default_nettype none

module cfi_inject_tb;
  logic core_clk, reset_n, cpu_source_preference;
  logic [1:0] expect_injection_header;
  logic grp0_valid, grp0_eof, grp0_ready, grp1_valid, grp1_eof, grp1_ready;
  logic [7:0] grp0_data, grp1_data, core_data, first;
  logic core_valid, core_sof, core_eof, core_masquerade, core_hdr_seen;
  logic core_bypass, core_prefer_src, core_egress_delay, core_smac_replace;
  logic core_mac_swap, core_ts_id_cpu, last;
  logic [3:0] core_group_port, core_ingress_port, core_injecting_port_number;
  logic [11:0] core_destination_set;
  logic [7:0] core_cpu_queue;
  logic [2:0] core_field_a;
  cfi_pkg::cfi_rew_cmd_type core_rew_cmd;
  logic [5:0] core_rew_arg;
  logic [31:0] core_rewriter_time_value;
  int err_total, checked, nb, ns;

  cfi_inject i_cfi_inject (.core_clk, .reset_n, .expect_injection_header,
    .cpu_source_preference, .grp0_valid, .grp0_data, .grp0_eof, .grp0_ready,
    .grp1_valid, .grp1_data, .grp1_eof, .grp1_ready, .core_valid,
    .core_data, .core_sof, .core_eof, .core_group_port, .core_ingress_port,
    .core_masquerade, .core_hdr_seen, .core_bypass, .core_destination_set,
    .core_cpu_queue, .core_field_a, .core_injecting_port_number,
    .core_prefer_src, .core_rew_cmd, .core_rew_arg, .core_egress_delay,
    .core_smac_replace, .core_mac_swap, .core_ts_id_cpu,
    .core_rewriter_time_value);
  cfi_cpu_model i_cpu0 (.core_clk, .valid(grp0_valid), .data(grp0_data),
    .eof(grp0_eof), .ready(grp0_ready));
  cfi_cpu_model i_cpu1 (.core_clk, .valid(grp1_valid), .data(grp1_data),
    .eof(grp1_eof), .ready(grp1_ready));

  // ==========================================================
  // Clock, monitor, checks
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (core_valid === 1'b1) begin
      nb <= nb + 1;
      last <= core_eof;
      if (core_sof === 1'b1) begin
        ns <= ns + 1;
        first <= core_data;
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic frame(input int g, input bit hd, input logic [159:0] h);
    logic [7:0] q[$];
    int n;
    nb = 0;
    ns = 0;
    first = 'x;
    if (hd) for (int k = 0; k < 20; k++) q.push_back(h[159-8*k -: 8]);
    q.push_back(8'h5a);
    q.push_back(8'h5b);
    q.push_back(8'h5c);
    if (g == 0) i_cpu0.send(q); else i_cpu1.send(q);
    repeat (4) @(posedge core_clk);
    n = (hd && expect_injection_header[g]) ? 3 : q.size();
    chk("byte count", n, nb);
    chk("first byte", (n == 3) ? 8'h5a : h[159:152], first);
    chk("group port", g ? 4'hc : 4'hb, core_group_port);
    chk("eof", 1, last);
  endtask

  function automatic logic [159:0] bhdr(input logic [8:0] op);
    logic [159:0] h = '0;
    h[127] = 1'b1;
    h[125:117] = op;
    h[116:85] = 32'h1234abcd;
    h[67:56] = 12'h801;
    h[46:43] = 4'hc;
    h[27:20] = 8'h44;
    h[19:17] = 3'h5;
    return h;
  endfunction

  task automatic s_plain();
    expect_injection_header <= 2'b00;
    cpu_source_preference <= 1'b1;
    frame(0, 1'b1, bhdr(9'h000));
    chk("bypass", 0, core_bypass);
    chk("hdr seen", 0, core_hdr_seen);
    chk("prefer", 1, core_prefer_src);
  endtask

  task automatic s_ops();
    logic [8:0] op[7] = '{9'h000, 9'h008, 9'h151, 9'h022, 9'h013, 9'h03b,
      9'h005};
    int ec[7] = '{0, 1, 2, 3, 4, 4, 5};
    logic [5:0] ea[7] = '{6'h00, 6'h00, 6'h2a, 6'h00, 6'h02, 6'h07, 6'h00};
    logic [2:0] ef[7] = '{3'h0, 3'h2, 3'h0, 3'h4, 3'h1, 3'h0, 3'h0};
    expect_injection_header <= 2'b11;
    cpu_source_preference <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      frame(i % 2, 1'b1, bhdr(op[i]));
      chk("rew cmd", ec[i], 32'(core_rew_cmd));
      chk("rew arg", ea[i], core_rew_arg);
      chk("flags", ef[i], {core_egress_delay, core_mac_swap,
        core_ts_id_cpu});
      chk("destination_set", 12'h801, core_destination_set);
      chk("cpuq", 8'h44, core_cpu_queue);
      chk("qos", 3'h5, core_field_a);
      chk("injecting_port_number", 4'hc, core_injecting_port_number);
      chk("time val", 32'h1234abcd, core_rewriter_time_value);
      chk("ingress", 4'hb, core_ingress_port);
      chk("smac", 0, {core_masquerade, core_smac_replace});
      chk("hdr seen", 1, core_hdr_seen);
      chk("prefer", 0, core_prefer_src);
    end
  endtask

  task automatic s_masquerade_enable();
    logic [159:0] h = '0;
    h[126] = 1'b1;
    h[125:122] = 4'h5;
    h[67:56] = 12'h7ff;
    frame(0, 1'b1, h);
    chk("ingress", 4'h5, core_ingress_port);
    chk("masquerade_enable smac", 3'h3, {core_bypass, core_masquerade,
      core_smac_replace});
    chk("destination_set", 0, core_destination_set);
    chk("rew cmd", 0, 32'(core_rew_cmd));
  endtask

  task automatic s_runt();
    logic [7:0] q[$] = '{8'h01, 8'h02, 8'h03};
    nb = 0;
    i_cpu0.send(q);
    repeat (4) @(posedge core_clk);
    chk("runt bytes", 0, nb);
  endtask

  task automatic s_both();
    logic [7:0] q[$] = '{8'h11, 8'h22, 8'h33};
    expect_injection_header <= 2'b00;
    nb = 0;
    ns = 0;
    fork
      i_cpu0.send(q);
      i_cpu1.send(q);
    join
    repeat (4) @(posedge core_clk);
    chk("both bytes", 6, nb);
    chk("both frames", 2, ns);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    err_total = 0;
    checked = 0;
    reset_n = 1'b0;
    expect_injection_header = 2'b00;
    cpu_source_preference = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge core_clk);
    s_plain();
    s_ops();
    s_masquerade_enable();
    s_runt();
    s_both();
    conclude();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    conclude();
  end
endmodule

`default_nettype wire
